// ### logic/fall_edge_delay.sv
// Purpose: Delays each falling edge of the source clock by a cycle count
// Assumes: src_clk is a level sampled on pclk
// Notes:   A rise does not cancel a pending fall; a new fall restarts the
//          count, so a delay longer than the period lets no edge through
`timescale 1ns/1ps
module fall_edge_delay
   import clk_edge_pkg::*;
#(
   parameter int unsigned W = DELAY_W
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         enable,
   input  wire logic         src_clk,
   input  wire logic [W-1:0] delay,
   output logic              fall_pulse
);

   edge_state_t state_reg;
   edge_state_t state_next;
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         prev_reg;
   logic         prev_next;
   logic         fall_reg;
   logic         fall_next;

   // Own counter per edge, independent of the rising side
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      prev_next  = src_clk;
      fall_next  = 1'b0;
      case (state_reg)
         ST_OFF: begin
            if (enable) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (prev_reg && !src_clk) begin
               if (delay == '0) begin
                  fall_next = 1'b1;
               end else begin
                  cnt_next   = delay;
                  state_next = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            // RULE4: newer fall restarts count; delay past the period drops all
            if (prev_reg && !src_clk) begin
               if (delay == '0) begin
                  fall_next  = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  cnt_next = delay;
               end
            end else if (cnt_reg == W'(1)) begin
               fall_next  = 1'b1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - W'(1);
            end
         end
         default: state_next = ST_OFF;
      endcase
      if (!enable) begin
         state_next = ST_OFF;
         fall_next  = 1'b0;
      end
   end

   // Registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_OFF;
         cnt_reg   <= '0;
         prev_reg  <= 1'b0;
         fall_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         prev_reg  <= prev_next;
         fall_reg  <= fall_next;
      end
   end

   assign fall_pulse = fall_reg;

endmodule : fall_edge_delay

// ### logic/port_clock_block_edge_ctrl.sv
// Purpose: Port clock block with falling-edge delay and ready-in selection
// Assumes: APB slave on pclk; source clock and port lines synchronous
// Notes:   Exceptions become sticky status bits and the irq output
// Notes on behaviour
// RULE1: Each falling edge reaches ports only after the programmed cycle delay.
// RULE2: Default falling-edge delay is zero cycles.
// RULE3: Delay range is 0 to 512 cycles inclusive.
// RULE4: Delay longer than the clock period lets no falling edge through.
// RULE5: Ready source that is not 1-bit raises an exception.
// RULE6: Selected ready-in gates when ports sample data.
// RULE7: Software should prefer combined port setup helpers over ready source alone.
// RULE8: Switching on loads all configuration defaults.
// RULE9: Switching on while running resets configuration to defaults.
// RULE10: Switching off while off does nothing.
// RULE11: Using the block while off raises an exception.
// RULE12: Falling delay has its own counter, independent of rising delay.
`timescale 1ns/1ps
module port_clock_block_edge_ctrl
   import clk_edge_pkg::*;
#(
   parameter int unsigned NPORTS = 1 << PORT_ID_W
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 src_clk,
   input  wire logic [NPORTS-1:0]    port_lines,
   output logic                      port_fall,
   output logic                      port_rise,
   output logic                      sample_en,
   output logic                      running,
   output logic                      irq
);

   logic                 on_reg;
   logic                 on_next;
   logic [DELAY_W-1:0]   fdly_reg;
   logic [DELAY_W-1:0]   fdly_next;
   logic                 rdy_en_reg;
   logic                 rdy_en_next;
   logic [PORT_ID_W-1:0] rdy_id_reg;
   logic [PORT_ID_W-1:0] rdy_id_next;
   logic [EV_W-1:0]      mask_reg;
   logic [EV_W-1:0]      mask_next;
   logic [31:0]          rdata_reg;
   logic [31:0]          rdata_next;
   logic                 rise_reg;
   logic                 rise_next;
   logic                 prev_clk_reg;
   logic                 samp_reg;
   logic                 samp_next;
   logic [EV_W-1:0]      events;
   logic [EV_W-1:0]      status;
   logic                 status_clear;
   logic                 fall_pulse;
   logic                 acc;
   logic                 wr;
   logic                 rd;
   logic                 use_attempt;
   logic                 known_addr;

   // Single-cycle access phase, zero wait states
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign pready  = 1'b1;

   always_comb begin
      case (paddr)
         OFF_CTRL, OFF_FDLY, OFF_RDY, OFF_STATUS, OFF_MASK, OFF_STATE: known_addr = 1'b1;
         default: known_addr = 1'b0;
      endcase
   end

   // Unmapped addresses answer with an error
   assign pslverr = acc & ~known_addr;

   // Configuration writes are "use"; on/off and status/mask are always allowed
   assign use_attempt = wr & ((paddr == OFF_FDLY) | (paddr == OFF_RDY));

   // Configuration next-state
   always_comb begin
      on_next     = on_reg;
      fdly_next   = fdly_reg;
      rdy_en_next = rdy_en_reg;
      rdy_id_next = rdy_id_reg;
      mask_next   = mask_reg;
      events      = '0;
      if (wr && paddr == OFF_CTRL) begin
         if (pwdata[CTRL_ON_BIT]) begin
            // RULE8: defaults on switch-on
            // RULE9: re-on also resets
            on_next     = 1'b1;
            fdly_next   = FDLY_DEFAULT;
            rdy_en_next = 1'b0;
            rdy_id_next = '0;
         end else if (pwdata[CTRL_OFF_BIT]) begin
            // RULE10: off when off is a no-op
            on_next = 1'b0;
         end
      end
      // RULE11: use while off excepts
      if (use_attempt && !on_reg) begin
         events[EV_OFF_EXC] = 1'b1;
      end else if (wr && paddr == OFF_FDLY) begin
         // RULE3: keep within 0..512
         if (pwdata[DELAY_W-1:0] > FDLY_MAX || |pwdata[31:DELAY_W]) begin
            events[EV_RANGE_EXC] = 1'b1;
         end else begin
            fdly_next = pwdata[DELAY_W-1:0];
         end
      end else if (wr && paddr == OFF_RDY) begin
         // RULE5: only 1-bit ports accepted
         if (pwdata[RDY_WID_LSB +: WIDTH_W] != ONE_BIT_PORT) begin
            events[EV_WIDTH_EXC] = 1'b1;
         end else begin
            rdy_en_next = pwdata[RDY_EN_BIT];
            rdy_id_next = pwdata[PORT_ID_W-1:0];
         end
      end
      if (wr && paddr == OFF_MASK) begin
         mask_next = pwdata[EV_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_reg     <= 1'b0;
         // RULE2: zero delay default
         fdly_reg   <= FDLY_DEFAULT;
         rdy_en_reg <= 1'b0;
         rdy_id_reg <= '0;
         mask_reg   <= '0;
      end else begin
         on_reg     <= on_next;
         fdly_reg   <= fdly_next;
         rdy_en_reg <= rdy_en_next;
         rdy_id_reg <= rdy_id_next;
         mask_reg   <= mask_next;
      end
   end

   // RULE1: delayed falling edge
   // RULE12: separate fall counter
   fall_edge_delay #(
      .W (DELAY_W)
   ) u_fall (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (on_reg),
      .src_clk    (src_clk),
      .delay      (fdly_reg),
      .fall_pulse (fall_pulse)
   );

   // Rising edge passes undelayed; its delay lives elsewhere
   // RULE6: ready-in qualifies sampling
   always_comb begin
      rise_next = on_reg & src_clk & ~prev_clk_reg;
      samp_next = rise_next & (~rdy_en_reg | port_lines[rdy_id_reg]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_clk_reg <= 1'b0;
         rise_reg     <= 1'b0;
         samp_reg     <= 1'b0;
      end else begin
         prev_clk_reg <= src_clk;
         rise_reg     <= rise_next;
         samp_reg     <= samp_next;
      end
   end

   assign port_fall = fall_pulse;
   assign port_rise = rise_reg;
   assign sample_en = samp_reg;
   assign running   = on_reg;

   // Status read clears it
   assign status_clear = rd & (paddr == OFF_STATUS);

   sticky_status #(
      .N (EV_W)
   ) u_stat (
      .pclk     (pclk),
      .presetn  (presetn),
      .event_in (events),
      .clear    (status_clear),
      .mask     (mask_reg),
      .status   (status),
      .irq      (irq)
   );

   // Read data registered at setup so it is stable in the access phase
   always_comb begin
      rdata_next = rdata_reg;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            OFF_FDLY:   rdata_next = {{(32-DELAY_W){1'b0}}, fdly_reg};
            OFF_RDY:    rdata_next = {rdy_en_reg, {(30-RDY_WID_LSB-WIDTH_W+1){1'b0}},
                                      ONE_BIT_PORT, {(RDY_WID_LSB-PORT_ID_W){1'b0}},
                                      rdy_id_reg};
            OFF_STATUS: rdata_next = {{(32-EV_W){1'b0}}, status};
            OFF_MASK:   rdata_next = {{(32-EV_W){1'b0}}, mask_reg};
            OFF_STATE:  rdata_next = {29'h0000000, src_clk, irq, on_reg};
            default:    rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign prdata = rdata_reg;

endmodule : port_clock_block_edge_ctrl

// ### logic/sticky_status.sv
// Purpose: Sticky event bits with mask and read-to-clear
// Assumes: Events are one-cycle pulses
// Notes:   A new event in the clearing cycle stays set
`timescale 1ns/1ps
module sticky_status #(
   parameter int unsigned N = 3
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] event_in,
   input  wire logic         clear,
   input  wire logic [N-1:0] mask,
   output logic [N-1:0]      status,
   output logic              irq
);

   logic [N-1:0] stat_reg;
   logic [N-1:0] stat_next;

   // Per-bit set-over-clear
   generate
      for (genvar i = 0; i < N; i++) begin : g_bit
         always_comb begin
            stat_next[i] = event_in[i] | (stat_reg[i] & ~clear);
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= '0;
      end else begin
         stat_reg <= stat_next;
      end
   end

   assign status = stat_reg;
   assign irq    = |(stat_reg & mask);

endmodule : sticky_status

// ### shared/clk_edge_pkg.sv
// Purpose: Shared constants for the port clock block falling-edge control
// Assumes: APB slave, 32-bit data, pclk at 25 MHz
// Notes:   Offsets are byte addresses of aligned words
package clk_edge_pkg;

   localparam int unsigned DELAY_W   = 10;     // Holds 0..512
   localparam int unsigned PORT_ID_W = 5;      // Port selector width
   localparam int unsigned WIDTH_W   = 6;      // Port width code width

   // Register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;  // Write: on/off command
   localparam logic [7:0] OFF_FDLY   = 8'h04;  // Falling-edge delay
   localparam logic [7:0] OFF_RDY    = 8'h08;  // Ready-in port select
   localparam logic [7:0] OFF_STATUS = 8'h0c;  // Sticky events, read clears
   localparam logic [7:0] OFF_MASK   = 8'h10;  // Interrupt mask
   localparam logic [7:0] OFF_STATE  = 8'h14;  // Live state

   // Control register bits
   localparam int unsigned CTRL_ON_BIT  = 0;
   localparam int unsigned CTRL_OFF_BIT = 1;

   // Ready-in select fields
   localparam int unsigned RDY_EN_BIT   = 31;
   localparam int unsigned RDY_WID_LSB  = 8;

   // Status bits
   localparam int unsigned EV_W          = 3;
   localparam int unsigned EV_WIDTH_EXC  = 0;  // Ready source not 1-bit
   localparam int unsigned EV_OFF_EXC    = 1;  // Use while switched off
   localparam int unsigned EV_RANGE_EXC  = 2;  // Delay out of range

   // Defaults
   localparam logic [DELAY_W-1:0] FDLY_DEFAULT = 10'h000;
   localparam logic [DELAY_W-1:0] FDLY_MAX     = 10'h200;  // 512 cycles
   localparam logic [WIDTH_W-1:0] ONE_BIT_PORT = 6'h01;

   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b11
   } edge_state_t;

endpackage : clk_edge_pkg

// ### verif/clk_edge_ctrl_assertions.sv
// Purpose: Port assertions for the clock block edge control
// Assumes: Zero-wait APB, block off after reset
// Notes:   Delay values are timed by the bench, not mirrored here
`timescale 1ns/1ps
module clk_edge_ctrl_assertions
   import clk_edge_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        src_clk,
   input wire logic        port_fall,
   input wire logic        port_rise,
   input wire logic        sample_en,
   input wire logic        running
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed write to the control word
   sequence s_ctrl_wr;
      psel && penable && pwrite && paddr == OFF_CTRL;
   endsequence
   // Source sampled low, then high
   sequence s_src_rose;
      !src_clk ##1 src_clk;
   endsequence
   a_on_starts: assert property (s_ctrl_wr ##0 pwdata[0] |=> running)
      else $error("switch-on ignored");
   a_off_stops: assert property (s_ctrl_wr ##0 pwdata[1:0] == 2'b10 |=> !running)
      else $error("switch-off ignored");
   a_run_stable: assert property (!(psel && penable && pwrite && paddr == OFF_CTRL)
      |=> $stable(running)) else $error("running moved without command");
   a_off_quiet: assert property (!running [*3] |-> !port_fall && !port_rise && !sample_en)
      else $error("edges while off");
   a_fall_running: assert property (port_fall |-> $past(running))
      else $error("fall while block off");
   a_fall_pulse: assert property (port_fall |=> !port_fall)
      else $error("fall pulse too long");
   a_rise_timing: assert property (s_src_rose ##1 $past(running)
      |-> port_rise) else $error("rise not passed on");
   a_sample_rise: assert property (sample_en |-> port_rise)
      else $error("sample off a rise");
   a_unmapped_err: assert property (psel && penable && paddr > OFF_STATE |-> pslverr) // Refusal
      else $error("unmapped access accepted");
   a_ready_high: assert property (pready) // Zero waits
      else $error("ready low");
endmodule : clk_edge_ctrl_assertions

// ### verif/cpu_model.sv
// Purpose: Processor side issuing configuration over APB
// Assumes: Slave answers through pready
// Notes:   Signals move only right after a rising edge
`timescale 1ns/1ps
module cpu_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : xfer
endmodule : cpu_model

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the clock block edge control
// Assumes: cpu_model issues APB, bench drives source clock and ports
// Notes:   Outputs sampled 1 ns after the edge so updates have landed
`timescale 1ns/1ps
module tb_top;
   import clk_edge_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, src_clk = 1'b1, se;
   logic [31:0] port_lines = 32'h0, pwdata, prdata, q;
   logic [7:0]  paddr;
   logic        psel, penable, pwrite, pready, pslverr, er;
   logic        port_fall, port_rise, sample_en, running, irq;
   int          fails = 0, checked = 0, falls = 0, k;
   always #20 pclk = ~pclk;
   // Tally of fall pulses, for dropped-edge checks
   always @(posedge pclk) if (port_fall === 1'b1) falls <= falls + 1;
   cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   port_clock_block_edge_ctrl i_port_clock_block_edge_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_clk(src_clk),
      .port_lines(port_lines), .port_fall(port_fall), .port_rise(port_rise),
      .sample_en(sample_en), .running(running), .irq(irq));
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d, q, er);
   endtask : wr
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      cpu.xfer(1'b0, a, 32'h0, q, er);
      check(n, q, e);
   endtask : rdc
   // Moves the source, returns edges until the matching pulse (0 if none)
   task automatic edge_to(input logic v, input int lim, output int n);
      @(posedge pclk) src_clk <= v;
      n = 0;
      se = 1'b0;
      for (int i = 1; i <= lim && n == 0; i++) begin
         @(posedge pclk);
         #1;
         if ((v ? port_rise : port_fall) === 1'b1) begin
            n = i;
            se = sample_en;
         end
      end
   endtask : edge_to
   task automatic t_off;
      wr(OFF_MASK, 32'h7);
      wr(OFF_CTRL, 32'h2);
      check("running", running, 0);
      check("irq", irq, 0);
      wr(OFF_FDLY, 32'h5);
      @(posedge pclk);
      #1;
      check("irq", irq, 1);
      rdc("status", OFF_STATUS, 32'h2);
      rdc("status", OFF_STATUS, 32'h0);
      cpu.xfer(1'b0, 8'h18, 32'h0, q, er);
      check("pslverr", er, 1);
      check("prdata", q, 0);
      $display("t_off done");
   endtask : t_off
   task automatic t_fall;
      int dl[3] = '{0, 1, 7};
      wr(OFF_CTRL, 32'h1);
      check("running", running, 1);
      rdc("fdly", OFF_FDLY, 32'h0);
      foreach (dl[i]) begin
         wr(OFF_FDLY, dl[i]);
         edge_to(1'b0, 20, k);
         check("fall lag", k, dl[i] + 1);
         edge_to(1'b1, 4, k);
      end
      wr(OFF_CTRL, 32'h1);
      rdc("fdly", OFF_FDLY, 32'h0);
      $display("t_fall done");
   endtask : t_fall
   task automatic t_range;
      int n;
      wr(OFF_FDLY, 32'h200);
      rdc("status", OFF_STATUS, 32'h0);
      wr(OFF_FDLY, 32'h201);
      rdc("status", OFF_STATUS, 32'h4);
      rdc("fdly", OFF_FDLY, 32'h200);
      n = falls;
      // Period of about 103 cycles, well under the 512-cycle delay
      repeat (6) begin
         edge_to(1'b0, 100, k);
         edge_to(1'b1, 4, k);
      end
      check("falls", falls, n);
      $display("t_range done");
   endtask : t_range
   task automatic t_ready;
      wr(OFF_CTRL, 32'h1);
      wr(OFF_RDY, 32'h8000_0203);
      rdc("status", OFF_STATUS, 32'h1);
      wr(OFF_RDY, 32'h8000_0103);
      rdc("status", OFF_STATUS, 32'h0);
      for (int v = 0; v < 2; v++) begin
         @(posedge pclk) port_lines[3] <= v[0];
         edge_to(1'b0, 8, k);
         edge_to(1'b1, 8, k);
         check("rise", k > 0, 1);
         check("sample", se, v[0]);
      end
      $display("t_ready done");
   endtask : t_ready
   task automatic t_stop;
      int n;
      wr(OFF_CTRL, 32'h2);
      check("running", running, 0);
      n = falls;
      edge_to(1'b0, 8, k);
      edge_to(1'b1, 8, k);
      check("falls", falls, n);
      $display("t_stop done");
   endtask : t_stop
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // Reset for two cycles, then the scenarios
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_off;
      t_fall;
      t_range;
      t_ready;
      t_stop;
      stop_test;
   end
   // Watchdog, several times the expected run
   initial begin
      repeat (5000) @(posedge pclk);
      fails++;
      stop_test;
   end
endmodule : tb_top
bind port_clock_block_edge_ctrl clk_edge_ctrl_assertions chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .src_clk(src_clk), .port_fall(port_fall),
   .port_rise(port_rise), .sample_en(sample_en), .running(running));
